// *** verilog/ddrseq_pkg.sv ***
// shared constants for the memory rail sequencer
package ddrseq_pkg;
    // clock and timebase
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // intervals in microseconds, as specified
    localparam int SS_UP_US = 1400;
    localparam int SS_DN_US = 2800;
    localparam int UV_US = 200;
    localparam int TERM_FAULT_US = 5000;
    localparam int ILIM_US = 160;
    // intervals in timebase ticks
    localparam int SS_UP_TICKS = (SS_UP_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
    localparam int SS_DN_TICKS = (SS_DN_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
    localparam int UV_TICKS = (UV_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
    localparam int TERM_TICKS = (TERM_FAULT_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
    localparam int ILIM_TICKS = (ILIM_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
    // pin input bit positions in the synchroniser bank
    localparam int IN_PDN = 0;
    localparam int IN_SLEEP = 1;
    localparam int IN_FPWM = 2;
    localparam int IN_OVP = 3;
    localparam int IN_POR = 4;
    localparam int IN_SUPPLY_LOCKOUT = 5;
    localparam int IN_MWIN = 6;
    localparam int IN_MOV = 7;
    localparam int IN_MUV = 8;
    localparam int IN_TWIN = 9;
    localparam int IN_THERM = 10;
    localparam int IN_PWM = 11;
    localparam int IN_VALLEY = 12;
    localparam int IN_NEG = 13;
    localparam int IN_ZC = 14;
    localparam int NUM_IN = 15;
    // register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FAULT_BIT = 8;
    localparam int ST_PG1_BIT = 9;
    localparam int ST_PG2_BIT = 10;
    localparam int ST_DIS_BIT = 11;
    localparam int ST_OVLAT_BIT = 12;
    localparam int ST_MODE_LSB = 16;
    // ramp full scale
    localparam logic [7:0] LEVEL_FULL = 8'hff;
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_IDLE = 5'h02,
        ST_START = 5'h04,
        ST_RUN = 5'h08,
        ST_SOFT = 5'h10
    } ddrseq_state_e;
    // operating modes, one-hot
    typedef enum logic [2:0] {
        MD_SKIP = 3'h1,
        MD_FPWM = 3'h2,
        MD_STBY = 3'h4
    } ddrseq_mode_e;
endpackage

// *** verilog/ddrseq_pin_if.sv ***
// raw and synchronised pin levels between top and synchroniser bank
`timescale 1ns/10ps
interface ddrseq_pin_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport syncer (input raw, output sync);
    modport user (output raw, input sync);
endinterface

// *** verilog/ddrseq_sync.sv ***
// two-flop synchroniser bank for asynchronous pin levels
`timescale 1ns/10ps
module ddrseq_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // pin levels
    ddrseq_pin_if.syncer pins
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // one two-flop stage per pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                meta_reg[i] <= 1'b0;
                sync_reg[i] <= 1'b0;
            end else begin
                meta_reg[i] <= pins.raw[i];
                sync_reg[i] <= meta_reg[i];
            end
        end
    end

    assign pins.sync = sync_reg;
endmodule

// *** verilog/ddrseq_top.sv ***
// sequencing, mode select, power-good and fault latch for a memory rail controller
`timescale 1ns/10ps
// Notes on behaviour
// [R1] forced-PWM: low gate complements high gate
// [R2] sleep select low forces standby mode
// [R3] shutdown always runs forced-PWM
// [R4] standby disables termination, reference stays on
// [R5] termination current limit ramps over 160us
// [R6] no new cycle above valley limit
// [R7] forced-PWM adds negative current limit
// [R8] main good low in shutdown and ramps
// [R9] main good floats only inside window
// [R10] rail fault latches off, both goods low
// [R11] overvoltage always pulls main good low
// [R12] term good low in standby, shutdown, start
// [R13] term good floats inside ten percent window
// [R14] term good low 5ms latches off
// [R15] power-on reset clears latch, discharge; here discharge on power-on needs the protect pin high
// [R16] lockout release starts soft-start
// [R17] lockout: stop, low gate low, discharge; here ov_lat_reg holds low gate high, discharge needs protect pin high
// [R18] power-down high ramps output over 1.4ms
// [R19] startup runs pulse-skip, selections after
// [R20] soft-shutdown causes: pin, thermal, faults
// [R21] ramp down 2.8ms then low gate low
// [R22] discharge holds until power-down rises; here it also drops whenever the protect pin is low
// [R23] intervals come from a tick timebase
module ddrseq_top
    import ddrseq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int T_SS_UP = SS_UP_TICKS,
    parameter int T_SS_DN = SS_DN_TICKS,
    parameter int T_UV = UV_TICKS,
    parameter int T_TERM = TERM_TICKS,
    parameter int T_ILIM = ILIM_TICKS
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // control pins, asynchronous
    input wire logic POWER_DOWN_N,
    input wire logic SLEEP_SELECT_N,
    input wire logic FORCED_PWM_SEL,
    input wire logic OVERVOLT_PROTECT_EN,
    // comparator levels, asynchronous
    input wire logic BIAS_POR_OK,
    input wire logic SUPPLY_LOCKOUT_OK,
    input wire logic MAIN_IN_WINDOW,
    input wire logic MAIN_OVERVOLT,
    input wire logic MAIN_UNDERVOLT,
    input wire logic TERM_IN_WINDOW,
    input wire logic THERMAL_FAULT,
    input wire logic ON_TIME_PULSE,
    input wire logic VALLEY_LIMIT,
    input wire logic NEG_LIMIT,
    input wire logic ZERO_CROSS,
    // gate drives
    output logic HIGH_SIDE_GATE,
    output logic LOW_SIDE_GATE,
    // open-drain power-good pins
    output logic MAIN_RAIL_OK_O,
    output logic MAIN_RAIL_OK_OE,
    output logic TERM_RAIL_OK_O,
    output logic TERM_RAIL_OK_OE,
    // analog block controls
    output logic [7:0] SS_LEVEL,
    output logic [7:0] TERM_ILIMIT,
    output logic TERM_EN,
    output logic TERM_REF_EN,
    output logic DISCHARGE_EN,
    output logic [2:0] MODE
);
    generate
        if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || T_SS_UP < 1 || T_SS_UP > 65535 ||
            T_SS_DN < 1 || T_SS_DN > 65535 || T_UV < 1 || T_TERM < 1 || T_TERM > 65535 ||
            T_ILIM < 1 || T_ILIM > 65535) begin : g_chk
            $error("ddrseq_top: interval parameter out of range");
        end
    endgenerate

    ddrseq_pin_if #(.W(NUM_IN)) pins ();
    logic [NUM_IN-1:0] s;
    ddrseq_state_e state_reg, state_next;
    ddrseq_mode_e mode_reg, mode_next;
    logic [15:0] tick_cnt_reg;
    logic tick;
    logic [15:0] ss_cnt_reg, ss_cnt_next;
    logic [15:0] uv_cnt_reg, tf_cnt_reg, ilim_cnt_reg;
    logic ilim_full_reg;
    logic pdn_d_reg, por_d_reg, pwm_d_reg;
    logic fault_reg, ov_lat_reg, dis_reg;
    logic hs_reg, hs_next, ls_reg;
    logic pg1_oe_reg, pg2_oe_reg;
    logic hold_reg;
    logic [7:0] level_reg, ilimit_reg;
    logic pdn_rise, pdn_fall, por_rise, ov_trip, uv_long, term_long, soft_cause;
    logic switching, term_en_c;
    logic wr_en;

    // pin levels into the synchroniser bank
    assign pins.raw = {ZERO_CROSS, NEG_LIMIT, VALLEY_LIMIT, ON_TIME_PULSE, THERMAL_FAULT,
                       TERM_IN_WINDOW, MAIN_UNDERVOLT, MAIN_OVERVOLT, MAIN_IN_WINDOW,
                       SUPPLY_LOCKOUT_OK, BIAS_POR_OK, OVERVOLT_PROTECT_EN, FORCED_PWM_SEL,
                       SLEEP_SELECT_N, POWER_DOWN_N};
    assign s = pins.sync;

    ddrseq_sync #(.W(NUM_IN)) u_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .pins(pins.syncer)
    );

    // free-running timebase
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end
    assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1)); // [R23]

    // edge history of synchronised levels
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pdn_d_reg <= 1'b0;
            por_d_reg <= 1'b0;
            pwm_d_reg <= 1'b0;
        end else begin
            pdn_d_reg <= s[IN_PDN];
            por_d_reg <= s[IN_POR];
            pwm_d_reg <= s[IN_PWM];
        end
    end
    assign pdn_rise = s[IN_PDN] && !pdn_d_reg;
    assign pdn_fall = !s[IN_PDN] && pdn_d_reg;
    assign por_rise = s[IN_POR] && !por_d_reg;

    // fault sources
    assign ov_trip = s[IN_MOV] && s[IN_OVP] && (state_reg == ST_START || state_reg == ST_RUN ||
                     state_reg == ST_SOFT);
    assign uv_long = (uv_cnt_reg >= 16'(T_UV)); // [R20]
    assign term_long = (tf_cnt_reg >= 16'(T_TERM)); // [R14]
    assign soft_cause = s[IN_THERM] || uv_long || term_long; // [R20]
    assign switching = state_reg == ST_START || state_reg == ST_RUN || state_reg == ST_SOFT;

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        ss_cnt_next = ss_cnt_reg;
        case (state_reg)
            ST_OFF: begin
                if (s[IN_POR] && s[IN_SUPPLY_LOCKOUT]) begin
                    if (s[IN_PDN] && !fault_reg && !hold_reg) begin
                        state_next = ST_START; // [R16]
                        ss_cnt_next = 16'h0000;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (pdn_rise && !fault_reg && !hold_reg) begin
                    state_next = ST_START; // [R18]
                    ss_cnt_next = 16'h0000;
                end
            end
            ST_START: begin
                if (ov_trip) begin
                    state_next = ST_IDLE;
                end else if (!s[IN_PDN] || soft_cause) begin
                    state_next = ST_SOFT;
                    ss_cnt_next = 16'((32'(ss_cnt_reg) * 32'(T_SS_DN)) / 32'(T_SS_UP));
                end else if (ss_cnt_reg >= 16'(T_SS_UP)) begin
                    state_next = ST_RUN; // [R18]
                end else if (tick) begin
                    ss_cnt_next = ss_cnt_reg + 16'h0001;
                end
            end
            ST_RUN: begin
                if (ov_trip) begin
                    state_next = ST_IDLE;
                end else if (!s[IN_PDN] || soft_cause) begin
                    state_next = ST_SOFT; // [R20]
                    ss_cnt_next = 16'(T_SS_DN);
                end
            end
            ST_SOFT: begin
                if (ov_trip || ss_cnt_reg == 16'h0000) begin
                    state_next = ST_IDLE; // [R21]
                end else if (tick) begin
                    ss_cnt_next = ss_cnt_reg - 16'h0001;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (!s[IN_POR] || !s[IN_SUPPLY_LOCKOUT]) begin
            state_next = ST_OFF; // [R17]
            ss_cnt_next = 16'h0000;
        end
    end

    // sequencer state and ramp position
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= ST_OFF;
            ss_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            ss_cnt_reg <= ss_cnt_next;
        end
    end

    // soft-start and soft-shutdown reference level
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            level_reg <= 8'h00;
        end else if (state_reg == ST_START) begin
            level_reg <= 8'((32'(ss_cnt_reg) * 32'(LEVEL_FULL)) / 32'(T_SS_UP)); // [R18]
        end else if (state_reg == ST_SOFT) begin
            level_reg <= 8'((32'(ss_cnt_reg) * 32'(LEVEL_FULL)) / 32'(T_SS_DN)); // [R21]
        end else if (state_reg == ST_RUN) begin
            level_reg <= LEVEL_FULL;
        end else begin
            level_reg <= 8'h00;
        end
    end

    // operating mode selection
    always_comb begin
        if (state_reg == ST_START) begin
            mode_next = MD_SKIP; // [R19]
        end else if (state_reg != ST_RUN) begin
            mode_next = MD_FPWM; // [R3]
        end else if (!s[IN_SLEEP]) begin
            mode_next = MD_STBY; // [R2]
        end else if (s[IN_FPWM]) begin
            mode_next = MD_FPWM;
        end else begin
            mode_next = MD_SKIP;
        end
    end
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_reg <= MD_FPWM;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // fault timers counted in ticks
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            uv_cnt_reg <= 16'h0000;
            tf_cnt_reg <= 16'h0000;
        end else begin
            if (state_reg != ST_RUN || !s[IN_MUV]) begin
                uv_cnt_reg <= 16'h0000;
            end else if (tick && !uv_long) begin
                uv_cnt_reg <= uv_cnt_reg + 16'h0001;
            end
            if (state_reg != ST_RUN || mode_reg == MD_STBY || !pg2_oe_reg) begin
                tf_cnt_reg <= 16'h0000;
            end else if (tick && !term_long) begin
                tf_cnt_reg <= tf_cnt_reg + 16'h0001; // [R14]
            end
        end
    end

    // fault latch, set wins over the power-down clear, power-on reset clear wins over set
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fault_reg <= 1'b0;
            ov_lat_reg <= 1'b0;
        end else if (!s[IN_POR]) begin
            fault_reg <= 1'b0; // [R15]
            ov_lat_reg <= 1'b0;
        end else if (ov_trip || (switching && soft_cause)) begin
            fault_reg <= 1'b1; // [R10]
            ov_lat_reg <= ov_lat_reg || ov_trip;
        end else if (pdn_fall) begin
            fault_reg <= 1'b0; // [R10]
            ov_lat_reg <= 1'b0;
        end
    end

    // output discharge switches
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            dis_reg <= 1'b0;
        end else if (!s[IN_OVP]) begin
            dis_reg <= 1'b0; // [R22]
        end else if (por_rise || (por_d_reg && !s[IN_SUPPLY_LOCKOUT]) || ov_trip) begin
            dis_reg <= 1'b1; // [R15] [R17]
        end else if (state_reg == ST_SOFT && state_next == ST_IDLE) begin
            dis_reg <= 1'b1; // [R22]
        end else if (state_next == ST_START) begin
            dis_reg <= 1'b0; // [R22]
        end
    end

    // high-side gate: one on-time per pulse, none above valley limit
    always_comb begin
        if (!switching || ov_lat_reg) begin
            hs_next = 1'b0;
        end else if (hs_reg) begin
            hs_next = s[IN_PWM];
        end else begin
            hs_next = s[IN_PWM] && !pwm_d_reg && !s[IN_VALLEY]; // [R6]
        end
    end

    // gate drive registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
        end else begin
            hs_reg <= hs_next;
            if (ov_lat_reg) begin
                ls_reg <= 1'b1;
            end else if (!switching) begin
                ls_reg <= 1'b0; // [R17] [R21]
            end else if (mode_reg == MD_FPWM) begin
                ls_reg <= !hs_next && !s[IN_NEG]; // [R1] [R7]
            end else begin
                ls_reg <= !hs_next && !s[IN_ZC];
            end
        end
    end

    // termination regulator current limit soft-start
    assign term_en_c = (state_reg == ST_START || state_reg == ST_SOFT ||
                        (state_reg == ST_RUN && mode_reg != MD_STBY)) && !fault_reg; // [R4]
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ilim_cnt_reg <= 16'h0000;
            ilim_full_reg <= 1'b0;
            ilimit_reg <= 8'h00;
        end else if (!term_en_c) begin
            ilim_cnt_reg <= 16'h0000;
            ilim_full_reg <= 1'b0;
            ilimit_reg <= 8'h00;
        end else begin
            if (tick && ilim_cnt_reg < 16'(T_ILIM)) begin
                ilim_cnt_reg <= ilim_cnt_reg + 16'h0001;
            end
            if (s[IN_TWIN] || ilim_cnt_reg >= 16'(T_ILIM)) begin
                ilim_full_reg <= 1'b1; // [R5]
            end
            if (ilim_full_reg) begin
                ilimit_reg <= LEVEL_FULL;
            end else begin
                ilimit_reg <= 8'((32'(ilim_cnt_reg) * 32'(LEVEL_FULL)) / 32'(T_ILIM)); // [R5]
            end
        end
    end

    // power-good open-drain enables, high pulls low
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pg1_oe_reg <= 1'b1;
            pg2_oe_reg <= 1'b1;
        end else begin
            pg1_oe_reg <= !(state_reg == ST_RUN && s[IN_MWIN] && !s[IN_MOV] &&
                            !fault_reg); // [R8] [R9] [R10] [R11]
            pg2_oe_reg <= !(state_reg == ST_RUN && mode_reg != MD_STBY && s[IN_TWIN] &&
                            !fault_reg); // [R12] [R13] [R10]
        end
    end

    // apb register file, zero wait states
    assign wr_en = PSEL && PENABLE && PWRITE && PADDR == CTRL_OFS;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hold_reg <= CTRL_RST[CTRL_HOLD_BIT];
        end else if (wr_en) begin
            hold_reg <= PWDATA[CTRL_HOLD_BIT];
        end
    end
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h0000_0000;
            if (PADDR == CTRL_OFS) begin
                PRDATA[CTRL_HOLD_BIT] <= hold_reg;
            end else if (PADDR == STATUS_OFS) begin
                PRDATA[ST_STATE_LSB +: 5] <= state_reg;
                PRDATA[ST_FAULT_BIT] <= fault_reg;
                PRDATA[ST_PG1_BIT] <= !pg1_oe_reg;
                PRDATA[ST_PG2_BIT] <= !pg2_oe_reg;
                PRDATA[ST_DIS_BIT] <= dis_reg;
                PRDATA[ST_OVLAT_BIT] <= ov_lat_reg;
                PRDATA[ST_MODE_LSB +: 3] <= mode_reg;
            end
        end
    end
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(PADDR == CTRL_OFS ||
                     (PADDR == STATUS_OFS && !PWRITE));

    // output drives
    assign HIGH_SIDE_GATE = hs_reg;
    assign LOW_SIDE_GATE = ls_reg;
    assign MAIN_RAIL_OK_O = 1'b0;
    assign MAIN_RAIL_OK_OE = pg1_oe_reg;
    assign TERM_RAIL_OK_O = 1'b0;
    assign TERM_RAIL_OK_OE = pg2_oe_reg;
    assign SS_LEVEL = level_reg;
    assign TERM_ILIMIT = ilimit_reg;
    assign TERM_EN = term_en_c;
    assign TERM_REF_EN = switching;
    assign DISCHARGE_EN = dis_reg;
    assign MODE = mode_reg;

    // checks on the sequencing behaviour
    sequence run_sleep_s;
        state_reg == ST_RUN && !s[IN_SLEEP];
    endsequence
    sequence ramp_phase_s;
        state_reg == ST_START || state_reg == ST_SOFT || state_reg == ST_IDLE;
    endsequence

    fpwm_complement_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R1]
        (switching && mode_reg == MD_FPWM && !ov_lat_reg && !s[IN_NEG] && !ov_trip &&
         state_next == state_reg) |=> (ls_reg == !hs_reg))
        else $error("low gate not complement in forced pwm");
    sleep_priority_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R2]
        run_sleep_s |=> mode_reg == MD_STBY)
        else $error("sleep select did not force standby");
    shutdown_fpwm_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R3]
        state_reg == ST_SOFT |=> mode_reg == MD_FPWM)
        else $error("soft shutdown not in forced pwm");
    standby_term_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R4]
        (state_reg == ST_RUN && mode_reg == MD_STBY) |-> (!TERM_EN && TERM_REF_EN))
        else $error("termination active in standby");
    valley_block_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R6]
        (!hs_reg && s[IN_VALLEY]) |=> !hs_reg)
        else $error("cycle started above valley limit");
    pg1_ramp_low_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R8]
        ramp_phase_s |=> MAIN_RAIL_OK_OE)
        else $error("main good released during ramp");
    ov_pull_low_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R11]
        s[IN_MOV] |=> MAIN_RAIL_OK_OE)
        else $error("overvoltage did not pull main good low");
    term_latch_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R14]
        (state_reg == ST_RUN && term_long && s[IN_POR] && s[IN_SUPPLY_LOCKOUT] && !ov_trip)
        |=> (state_reg == ST_SOFT && fault_reg))
        else $error("term fault did not latch off");
    lockout_stop_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R17]
        (!s[IN_SUPPLY_LOCKOUT] && !ov_lat_reg) |=> (state_reg == ST_OFF ##1 !LOW_SIDE_GATE && !hs_reg))
        else $error("lockout did not stop the controller");
    start_skip_a: assert property (@(posedge CLK) disable iff (!RSTN) // [R19]
        state_reg == ST_START |=> mode_reg == MD_SKIP)
        else $error("startup not in pulse skip");
endmodule

// *** verif/ddrseq_host.sv ***
// host control pins and supervisor model with power-good pull-ups
`timescale 1ns/10ps
module ddrseq_host (
    // clock
    input wire logic clk,
    // requested levels from the test sequence
    input wire logic [5:0] cmd,
    // open-drain pulls from the sequencer
    input wire logic main_oe,
    input wire logic main_o,
    input wire logic term_oe,
    input wire logic term_o,
    // pin levels and resolved power-good lines
    output logic [5:0] pins = 6'h00,
    output logic main_ok,
    output logic term_ok
);
    // pins move just after the edge; power-down high starts the rail
    always @(posedge clk) begin
        pins <= cmd;
    end
    // pull-ups win whenever the sequencer lets go of a line
    assign main_ok = main_oe ? main_o : 1'b1;
    assign term_ok = term_oe ? term_o : 1'b1;
endmodule

// *** verif/ddrseq_top_tb.sv ***
// self-checking bench for the memory rail sequencer
`timescale 1ns/10ps
module ddrseq_top_tb
    import ddrseq_pkg::*;
;
    // bus, pin and comparator levels
    logic CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rdat;
    logic PREADY, PSLVERR, err, main_ok, term_ok, MAIN_UNDERVOLT = 1'b0;
    logic MAIN_OVERVOLT = 1'b0, THERMAL_FAULT = 1'b0, ZERO_CROSS = 1'b0;
    logic ON_TIME_PULSE = 1'b0, VALLEY_LIMIT = 1'b0, NEG_LIMIT = 1'b0;
    logic POWER_DOWN_N, SLEEP_SELECT_N, FORCED_PWM_SEL, OVERVOLT_PROTECT_EN;
    logic BIAS_POR_OK, SUPPLY_LOCKOUT_OK, MAIN_IN_WINDOW, TERM_IN_WINDOW;
    logic HIGH_SIDE_GATE, LOW_SIDE_GATE, MAIN_RAIL_OK_O, MAIN_RAIL_OK_OE;
    logic TERM_RAIL_OK_O, TERM_RAIL_OK_OE, TERM_EN, TERM_REF_EN, DISCHARGE_EN;
    logic [7:0] SS_LEVEL, TERM_ILIMIT;
    logic [2:0] MODE;
    logic [5:0] cmd = 6'h00, pins;
    int failures = 0, check_count = 0;
    // host order: lockout, por, protect, forced pwm, sleep_n, power-down_n
    assign {SUPPLY_LOCKOUT_OK, BIAS_POR_OK, OVERVOLT_PROTECT_EN, FORCED_PWM_SEL,
            SLEEP_SELECT_N, POWER_DOWN_N} = pins;
    assign MAIN_IN_WINDOW = (SS_LEVEL == LEVEL_FULL) && !MAIN_UNDERVOLT;
    assign TERM_IN_WINDOW = TERM_EN;
    always #2 CLK = ~CLK;
    ddrseq_top #(.TICK_CYCLES(1), .T_SS_UP(14), .T_SS_DN(28), .T_UV(4), .T_TERM(20),
        .T_ILIM(8)) ddrseq_top_inst (.*);
    ddrseq_host ddrseq_host_inst (.clk(CLK), .cmd(cmd), .main_oe(MAIN_RAIL_OK_OE),
        .main_o(MAIN_RAIL_OK_O), .term_oe(TERM_RAIL_OK_OE), .term_o(TERM_RAIL_OK_O),
        .pins(pins), .main_ok(main_ok), .term_ok(term_ok));
    // counts, verdict and end of run
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task fail_out;
        failures++;
        give_verdict();
    endtask
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) fail_out();
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // polls the state field under a bound
    task wait_st(input logic [4:0] s);
        for (int n = 0; n < 60; n++) begin
            apb(1'b0, STATUS_OFS, 32'h0000_0000);
            if (rdat[4:0] === s) break;
        end
        if (rdat[4:0] !== s) fail_out();
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk(rdat, CTRL_RST);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk({err, rdat}, 33'h1_0000_0000);
        apb(1'b1, STATUS_OFS, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        cmd <= 6'h3f;
        repeat (12) @(posedge CLK);
        chk({DISCHARGE_EN, main_ok}, 2'b10);
        wait_st(ST_IDLE); // hold bit refuses the start
        $display("test reset, map and hold done");
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        cmd <= 6'h3e;
        repeat (4) @(posedge CLK);
        cmd <= 6'h3f;
        wait_st(ST_START);
        chk({MODE, SS_LEVEL == LEVEL_FULL, term_ok, main_ok}, {MD_SKIP, 3'b000});
        wait_st(ST_RUN);
        repeat (8) @(posedge CLK);
        chk({MODE, main_ok, term_ok, TERM_ILIMIT}, {MD_FPWM, 2'b11, LEVEL_FULL});
        ON_TIME_PULSE <= 1'b1;
        repeat (5) @(posedge CLK);
        chk({HIGH_SIDE_GATE, LOW_SIDE_GATE}, 2'b10);
        ON_TIME_PULSE <= 1'b0;
        repeat (5) @(posedge CLK);
        chk({HIGH_SIDE_GATE, LOW_SIDE_GATE}, 2'b01);
        NEG_LIMIT <= 1'b1;
        repeat (5) @(posedge CLK);
        chk(LOW_SIDE_GATE, 1'b0);
        NEG_LIMIT <= 1'b0;
        VALLEY_LIMIT <= 1'b1;
        ON_TIME_PULSE <= 1'b1;
        repeat (5) @(posedge CLK);
        chk(HIGH_SIDE_GATE, 1'b0);
        ON_TIME_PULSE <= 1'b0;
        VALLEY_LIMIT <= 1'b0;
        cmd <= 6'h37;
        repeat (4) @(posedge CLK);
        MAIN_OVERVOLT <= 1'b1;
        repeat (5) @(posedge CLK);
        chk({main_ok, DISCHARGE_EN, MODE}, {2'b00, MD_FPWM});
        MAIN_OVERVOLT <= 1'b0;
        $display("test start-up and gates done");
        cmd <= 6'h3d;
        repeat (8) @(posedge CLK);
        chk({MODE, TERM_EN, TERM_REF_EN, term_ok}, {MD_STBY, 3'b010});
        cmd <= 6'h3c;
        repeat (7) @(posedge CLK);
        chk({MODE, main_ok}, {MD_FPWM, 1'b0});
        wait_st(ST_SOFT);
        wait_st(ST_IDLE);
        chk({LOW_SIDE_GATE, DISCHARGE_EN}, 2'b01);
        $display("test standby and shutdown done");
        cmd <= 6'h3f;
        wait_st(ST_RUN);
        MAIN_UNDERVOLT <= 1'b1;
        wait_st(ST_SOFT);
        chk({rdat[ST_FAULT_BIT], main_ok, term_ok}, 3'b100);
        MAIN_UNDERVOLT <= 1'b0;
        wait_st(ST_IDLE);
        cmd <= 6'h3e;
        repeat (6) @(posedge CLK);
        cmd <= 6'h3f;
        wait_st(ST_START);
        THERMAL_FAULT <= 1'b1;
        wait_st(ST_SOFT);
        chk(rdat[ST_FAULT_BIT], 1'b1);
        THERMAL_FAULT <= 1'b0;
        cmd <= 6'h1f;
        repeat (6) @(posedge CLK);
        chk({LOW_SIDE_GATE, DISCHARGE_EN}, 2'b01);
        wait_st(ST_OFF);
        $display("test fault latch and lockout done");
        give_verdict();
    end
endmodule
